/* fapd_pkg.sv */
// Package for the flash array protection decoder: status bit positions,
// opcodes, array geometry and carrier structs.
// Assumes a 24-bit byte address array of 16MB.
package fapd_pkg;
  localparam int ADDR_W = 24;
  // Status byte two bit positions, relative to the byte (S8..S15)
  localparam int SR2_QE_POS = 1;
  localparam int SR2_CMP_POS = 6;
  localparam int SR2_SUS_POS = 7;
  localparam int SR2_RSV_LO = 2;
  localparam int SR2_RSV_HI = 5;
  // Status byte one bit positions
  localparam int SR1_BP_LO = 2;
  localparam int SR1_TB_POS = 5;
  localparam int SR1_SEC_POS = 6;
  // Reset values of the non-volatile image
  localparam logic [7:0] SR2_RESET = 8'h00;
  localparam logic [2:0] LEVEL_RESET = 3'h0;
  // Opcodes
  localparam logic [7:0] OP_SUSPEND = 8'h75;
  localparam logic [7:0] OP_RESUME = 8'h7A;
  // Region sizes as address-bit shifts
  localparam int BLOCK_SHIFT = 18;
  localparam int SECTOR_SHIFT = 12;
  localparam logic [ADDR_W-1:0] ADDR_TOP = 24'hFFFFFF;

  typedef struct packed {
    logic protection_complement;
    logic quad_io_enable;
    logic suspend_flag;
    logic sector_granularity;
    logic bottom_select;
    logic [2:0] protect_level;
  } fapd_status_type;

  typedef struct packed {
    logic valid;
    logic [ADDR_W-1:0] first;
    logic [ADDR_W-1:0] last;
  } fapd_span_type;
endpackage : fapd_pkg

/* fapd_range.sv */
// Combinational decoder: protection fields to a protected address range.
// Assumes fields come straight from the held status image.
`timescale 1ns/1ps
module fapd_range
  import fapd_pkg::*;
(
  input wire fapd_status_type stat, // Current protection fields
  output logic protAny, // Some part is protected
  output logic [ADDR_W-1:0] protLo, // First protected address
  output logic [ADDR_W-1:0] protHi // Last protected address
);
  logic [ADDR_W-1:0] size;
  logic [ADDR_W-1:0] baseLo;
  logic [ADDR_W-1:0] baseHi;
  logic baseAny;
  logic baseAll;
  always_comb begin
    size = '0;
    baseAll = (stat.protect_level == 3'h7);
    baseAny = (stat.protect_level != 3'h0);
    if (stat.sector_granularity) begin
      if (stat.protect_level[2]) begin
        size = ADDR_W'(1) << (SECTOR_SHIFT + 3);
      end else begin
        size = ADDR_W'(1) << (SECTOR_SHIFT - 1 + int'(stat.protect_level[1:0]));
      end
    end else begin
      size = ADDR_W'(1) << (BLOCK_SHIFT - 1 + int'(stat.protect_level));
    end
    if (stat.bottom_select) begin
      baseLo = '0;
      baseHi = size - ADDR_W'(1);
    end else begin
      baseLo = ADDR_TOP - size + ADDR_W'(1);
      baseHi = ADDR_TOP;
    end
    if (baseAll) begin
      baseLo = '0;
      baseHi = ADDR_TOP;
    end
    protAny = baseAny;
    protLo = baseLo;
    protHi = baseHi;
    if (stat.protection_complement) begin
      protAny = !baseAll;
      if (!baseAny) begin
        protLo = '0;
        protHi = ADDR_TOP;
      end else if (stat.bottom_select) begin
        protLo = baseHi + ADDR_W'(1);
        protHi = ADDR_TOP;
      end else begin
        protLo = '0;
        protHi = baseLo - ADDR_W'(1);
      end
    end
  end
endmodule : fapd_range

/* fapd_core.sv */
// Status byte two and array protection gate of the serial flash.
// Assumes the command decoder presents whole, decoded commands in core_clk.
`timescale 1ns/1ps
module fapd_core
  import fapd_pkg::*;
(
  input wire logic core_clk, // 250 MHz clock
  input wire logic nrst, // Async reset, power cycle
  input wire logic statusWrite, // Pulse: write both status bytes
  input wire logic [7:0] statusOneIn, // Byte one write data
  input wire logic [7:0] statusTwoIn, // Byte two write data
  input wire logic opValid, // Pulse: command opcode executed
  input wire logic [7:0] opCode, // Opcode of that command
  input wire fapd_span_type cmdSpan, // Erase/program address span
  input wire logic wpPin, // Write-protect pin, active low
  input wire logic pausePin, // Pause pin, active low
  output logic [7:0] statusOneOut, // Protection fields of byte one
  output logic [7:0] status_byte_two, // Byte two readback
  output logic cmdAccept, // Span allowed, pulse
  output logic cmdReject, // Span refused, pulse
  output logic wpActiveN, // Write protect asserted, active low
  output logic pauseActiveN, // Pause asserted, active low
  output logic quadLines // Pins serve as data lines 3 and 4
);
  typedef struct packed {
    fapd_status_type stat;
    logic accept;
    logic reject;
    logic [1:0] wpSync;
    logic [1:0] pauseSync;
  } fapd_state_type;

  fapd_state_type st;
  fapd_state_type next_st;
  logic protAny;
  logic [ADDR_W-1:0] protLo;
  logic [ADDR_W-1:0] protHi;
  logic overlap;

  fapd_range uRange (
    .stat(st.stat),
    .protAny(protAny),
    .protLo(protLo),
    .protHi(protHi)
  );

  // Overlap if spans intersect at all
  assign overlap = protAny && !(cmdSpan.last < protLo || cmdSpan.first > protHi);

  always_comb begin
    next_st = st;
    next_st.accept = 1'b0;
    next_st.reject = 1'b0;
    next_st.wpSync = {st.wpSync[0], wpPin};
    next_st.pauseSync = {st.pauseSync[0], pausePin};
    if (statusWrite) begin
      next_st.stat.protection_complement = statusTwoIn[SR2_CMP_POS];
      next_st.stat.quad_io_enable = statusTwoIn[SR2_QE_POS];
      next_st.stat.bottom_select = statusOneIn[SR1_TB_POS];
      next_st.stat.sector_granularity = statusOneIn[SR1_SEC_POS];
      next_st.stat.protect_level = statusOneIn[SR1_BP_LO +: 3];
    end
    // Resume clears; suspend sets and is checked last so it wins
    if (opValid && opCode == OP_RESUME) begin
      next_st.stat.suspend_flag = 1'b0;
    end
    if (opValid && opCode == OP_SUSPEND) begin
      next_st.stat.suspend_flag = 1'b1;
    end
    if (cmdSpan.valid) begin
      next_st.accept = !overlap;
      next_st.reject = overlap;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
      st.stat.protect_level <= LEVEL_RESET;
      st.wpSync <= 2'h3;
      st.pauseSync <= 2'h3;
    end else begin
      st <= next_st;
    end
  end

  always_comb begin
    status_byte_two = SR2_RESET;
    status_byte_two[SR2_CMP_POS] = st.stat.protection_complement;
    status_byte_two[SR2_QE_POS] = st.stat.quad_io_enable;
    status_byte_two[SR2_SUS_POS] = st.stat.suspend_flag;
    statusOneOut = 8'h00;
    statusOneOut[SR1_SEC_POS] = st.stat.sector_granularity;
    statusOneOut[SR1_TB_POS] = st.stat.bottom_select;
    statusOneOut[SR1_BP_LO +: 3] = st.stat.protect_level;
  end

  assign cmdAccept = st.accept;
  assign cmdReject = st.reject;
  // Pin functions only while quad lines are off
  assign quadLines = st.stat.quad_io_enable;
  assign wpActiveN = st.stat.quad_io_enable | st.wpSync[1];
  assign pauseActiveN = st.stat.quad_io_enable | st.pauseSync[1];

  a_suspend_set: assert property (@(posedge core_clk) disable iff (!nrst)
    opValid && opCode == OP_SUSPEND |=> status_byte_two[SR2_SUS_POS])
    else $error("suspend flag not set");
  a_resume_clear: assert property (@(posedge core_clk) disable iff (!nrst)
    opValid && opCode == OP_RESUME |=> !status_byte_two[SR2_SUS_POS])
    else $error("suspend flag not cleared");
  a_reserved_zero: assert property (@(posedge core_clk) disable iff (!nrst)
    status_byte_two[SR2_RSV_HI:SR2_RSV_LO] == 4'h0)
    else $error("reserved bits nonzero");
  a_cmp_write: assert property (@(posedge core_clk) disable iff (!nrst)
    statusWrite |=> status_byte_two[SR2_CMP_POS] == $past(statusTwoIn[SR2_CMP_POS]))
    else $error("complement bit not stored");
  a_level_write: assert property (@(posedge core_clk) disable iff (!nrst)
    statusWrite |=> statusOneOut[SR1_BP_LO +: 3] == $past(statusOneIn[SR1_BP_LO +: 3]))
    else $error("protect level not stored");
  a_reject_hit: assert property (@(posedge core_clk) disable iff (!nrst)
    cmdSpan.valid && overlap |=> cmdReject && !cmdAccept)
    else $error("protected span accepted");
  a_accept_clear: assert property (@(posedge core_clk) disable iff (!nrst)
    cmdSpan.valid && !protAny |=> cmdAccept)
    else $error("unprotected span refused");
  a_quad_pins: assert property (@(posedge core_clk) disable iff (!nrst)
    quadLines |-> wpActiveN && pauseActiveN)
    else $error("pin function active in quad mode");
  a_all_level: assert property (@(posedge core_clk) disable iff (!nrst)
    statusOneOut[SR1_BP_LO +: 3] == 3'h7 && !status_byte_two[SR2_CMP_POS]
    |-> protLo == 24'h000000 && protHi == ADDR_TOP)
    else $error("level seven not whole array");
  // Complement, 4KB sectors, top end, level 10X; quad and suspend bits are don't care
  a_cmp_sector: assert property (@(posedge core_clk) disable iff (!nrst)
    st.stat.protection_complement && st.stat.sector_granularity && !st.stat.bottom_select
    && st.stat.protect_level[2:1] == 2'b10
    |-> protAny && protLo == 24'h000000 && protHi == 24'hFF7FFF)
    else $error("complement sector range wrong");

  c_reject: cover property (@(posedge core_clk) disable iff (!nrst) cmdReject);
  c_accept: cover property (@(posedge core_clk) disable iff (!nrst) cmdAccept);
  c_suspend: cover property (@(posedge core_clk) disable iff (!nrst)
    status_byte_two[SR2_SUS_POS]);
  c_quad: cover property (@(posedge core_clk) disable iff (!nrst) quadLines);
endmodule : fapd_core

/* fapd_host.sv */
// Host model: status writes, opcodes and erase/program spans.
// Assumes its tasks are started at a falling edge of core_clk.
`timescale 1ns/1ps
module fapd_host
  import fapd_pkg::*;
(
  input wire logic core_clk, // Clock
  output logic statusWrite, // Status write pulse
  output logic [7:0] statusOneIn, // Byte one data
  output logic [7:0] statusTwoIn, // Byte two data
  output logic opValid, // Opcode pulse
  output logic [7:0] opCode, // Opcode
  output fapd_span_type cmdSpan // Span request
);
  initial begin
    statusWrite = 1'b0;
    opValid = 1'b0;
    statusOneIn = 8'hA5;
    statusTwoIn = 8'h5A;
    opCode = 8'h00;
    cmdSpan = '0;
  end
  // Reserved bits go out as zero during the pulse; both data bytes are inverted after it
  task automatic wr_status(input logic [7:0] one, input logic cmp, input logic qe);
    statusOneIn = one;
    statusTwoIn = {1'b0, cmp, 4'h0, qe, 1'b0};
    statusWrite = 1'b1;
    @(negedge core_clk);
    statusWrite = 1'b0;
    statusOneIn = ~one;
    statusTwoIn = ~statusTwoIn;
    @(negedge core_clk);
  endtask : wr_status
  task automatic op(input logic [7:0] code);
    opCode = code;
    opValid = 1'b1;
    @(negedge core_clk);
    opValid = 1'b0;
    opCode = ~code;
    @(negedge core_clk);
  endtask : op
  // Valid stays up across back-to-back spans
  task automatic span(input logic [23:0] f, input logic [23:0] l);
    cmdSpan = {1'b1, f, l};
    @(negedge core_clk);
  endtask : span
  task automatic span_idle();
    cmdSpan = {1'b0, ~cmdSpan.first, ~cmdSpan.last};
    @(negedge core_clk);
  endtask : span_idle
endmodule : fapd_host

/* testbench.sv */
// Self-checking bench for the status byte two and protection gate.
// Assumes results pulse one cycle after the taking edge.
`timescale 1ns/1ps
module testbench;
  import fapd_pkg::*;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic wpPin = 1'b1;
  logic pausePin = 1'b1;
  logic statusWrite, opValid, cmdAccept, cmdReject, wpActiveN, pauseActiveN, quadLines;
  logic [7:0] statusOneIn, statusTwoIn, opCode, statusOneOut, status_byte_two;
  fapd_span_type cmdSpan;
  int fail_count = 0;
  int checks_done = 0;
  logic expQ[$];
  always #2 core_clk = ~core_clk;
  fapd_host host(.core_clk(core_clk), .statusWrite(statusWrite), .statusOneIn(statusOneIn),
    .statusTwoIn(statusTwoIn), .opValid(opValid), .opCode(opCode), .cmdSpan(cmdSpan));
  fapd_core uut(.core_clk(core_clk), .nrst(nrst), .statusWrite(statusWrite),
    .statusOneIn(statusOneIn), .statusTwoIn(statusTwoIn), .opValid(opValid), .opCode(opCode),
    .cmdSpan(cmdSpan), .wpPin(wpPin), .pausePin(pausePin), .statusOneOut(statusOneOut),
    .status_byte_two(status_byte_two), .cmdAccept(cmdAccept), .cmdReject(cmdReject),
    .wpActiveN(wpActiveN), .pauseActiveN(pauseActiveN), .quadLines(quadLines));
  task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : check8
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_sim
  task automatic do_reset();
    nrst = 1'b0;
    repeat (5) @(negedge core_clk);
    nrst = 1'b1;
  endtask : do_reset
  // Returns {any, lo, hi}; complement flips the range around the array
  function automatic logic [48:0] exp_range(input logic cmp, sec, tb, input logic [2:0] lvl);
    logic [23:0] sz, lo, hi;
    sz = sec ? (24'h001000 << ((lvl > 3'h3) ? 3'h3 : lvl - 3'h1)) : (24'h040000 << (lvl - 3'h1));
    lo = tb ? 24'h000000 : ADDR_TOP - sz + 24'h000001;
    hi = tb ? sz - 24'h000001 : ADDR_TOP;
    if (lvl == 3'h0 || lvl == 3'h7) return {(lvl == 3'h7) ^ cmp, 24'h000000, ADDR_TOP};
    if (cmp && tb) return {1'b1, hi + 24'h000001, ADDR_TOP};
    if (cmp) return {1'b1, 24'h000000, lo - 24'h000001};
    return {1'b1, lo, hi};
  endfunction : exp_range
  task automatic probe(input logic [23:0] f, input logic [23:0] l, input logic [48:0] r);
    expQ.push_back(r[48] && f <= r[23:0] && l >= r[47:24]);
    host.span(f, l);
  endtask : probe
  always @(negedge core_clk) begin
    if (nrst && (cmdAccept === 1'b1 || cmdReject === 1'b1)) begin
      if (expQ.size() == 0) check8("spurious result", 8'h00, 8'h01);
      else check8("reject", {7'h00, expQ.pop_front()}, {7'h00, cmdReject});
      check8("accept", {7'h00, ~cmdReject}, {7'h00, cmdAccept});
    end
  end
  initial begin
    #20000;
    fail_count++;
    end_sim();
  end
  initial begin
    logic [48:0] r;
    logic cmp, sec, tb;
    logic [2:0] lvl;
    logic [23:0] f;
    void'($urandom(82039));
    do_reset();
    check8("status one", 8'h00, statusOneOut);
    check8("status two", 8'h00, status_byte_two);
    probe(24'h000000, ADDR_TOP, exp_range(1'b0, 1'b0, 1'b0, 3'h0));
    host.span_idle();
    host.op(OP_SUSPEND);
    check8("suspend set", 8'h80, status_byte_two);
    host.wr_status(8'h00, 1'b0, 1'b0);
    check8("suspend kept", 8'h80, status_byte_two);
    host.op(OP_RESUME);
    check8("suspend cleared", 8'h00, status_byte_two);
    host.op(OP_SUSPEND);
    do_reset();
    check8("suspend power cycle", 8'h00, status_byte_two);
    $display("test status and suspend done");
    wpPin = 1'b0;
    pausePin = 1'b0;
    repeat (4) @(negedge core_clk);
    check8("pins normal", 8'h00, {5'h00, wpActiveN, pauseActiveN, quadLines});
    host.wr_status(8'h00, 1'b0, 1'b1);
    repeat (3) @(negedge core_clk);
    check8("pins quad", 8'h07, {5'h00, wpActiveN, pauseActiveN, quadLines});
    check8("quad bit", 8'h02, status_byte_two);
    host.wr_status(8'h00, 1'b0, 1'b0);
    wpPin = 1'b1;
    pausePin = 1'b1;
    $display("test pins done");
    for (int c = 0; c < 64; c++) begin
      {cmp, sec, tb, lvl} = c[5:0];
      if (sec && lvl == 3'h6) continue;
      host.wr_status({1'b0, sec, tb, lvl, 2'b00}, cmp, 1'b0);
      check8("status one", {1'b0, sec, tb, lvl, 2'b00}, statusOneOut);
      check8("status two", {1'b0, cmp, 6'h00}, status_byte_two);
      r = exp_range(cmp, sec, tb, lvl);
      f = 24'($urandom());
      probe(r[47:24] - 24'h000001, r[47:24] - 24'h000001, r);
      probe(r[47:24], r[47:24], r);
      probe(r[23:0], r[23:0], r);
      probe(r[23:0] + 24'h000001, r[23:0] + 24'h000001, r);
      probe(f, f | 24'($urandom() & 32'h0000FFFF), r);
      host.span_idle();
    end
    $display("test protection ranges done");
    host.span_idle();
    check8("pending results", 8'h00, 8'(expQ.size()));
    end_sim();
  end
endmodule : testbench
